// *** hw/ppp_port.v ***
// Parallel programming port of the on-chip nonvolatile storage, with its page-load FIFO.
// Assumes all pins are asynchronous to sys_clk and strobes last several clock periods.
`include "ppp_consts.vh"

module ppp_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ppp_fifo

module ppp_port #(
  parameter [7:0]  SIG_BYTE0   = 8'h5a, // Arbitrary identification value.
  parameter [7:0]  SIG_BYTE1   = 8'h3c, // Arbitrary identification value.
  parameter [7:0]  SIG_BYTE2   = 8'h0f, // Arbitrary identification value.
  parameter [7:0]  CAL_BYTE    = 8'h80,
  parameter [15:0] WRITE_CYCLES = `PPP_WRITE_CYCLES,
  parameter        FIFO_DEPTH  = 8
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       hv_detect,
  input  wire       crystal_input_strobe,
  input  wire       action_select_high,
  input  wire       action_select_low,
  input  wire       byte_select_one,
  input  wire       byte_select_two,
  input  wire       page_load_strobe,
  input  wire       write_strobe_n,
  input  wire       output_enable_n,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_n,
  output reg        ready_busy_flag,
  output reg        prog_mode,
  output reg  [7:0] fuse_low_active,
  output reg  [7:0] fuse_high_active,
  output reg  [7:0] fuse_ext_active,
  output reg  [7:0] lock_bits,
  output wire       eeprom_preserve_fuse,
  output wire       serial_program_enable_fuse,
  output reg  [7:0] oscillator_calibration_register
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ERASE = 3'h1;
  localparam [2:0] ST_FLASH = 3'h2;
  localparam [2:0] ST_EE    = 3'h3;
  localparam [2:0] ST_WAIT  = 3'h4;

  // Pins are synchronised as one vector; stage three only feeds the edge detectors.
  wire [16:0] pins = {hv_detect, crystal_input_strobe, action_select_high, action_select_low,
                      byte_select_one, byte_select_two, page_load_strobe, write_strobe_n,
                      output_enable_n, data_in};
  reg  [16:0] pin_s1;
  reg  [16:0] pin_s2;
  reg  [16:0] pin_s3;

  wire [7:0] din      = pin_s2[7:0];
  wire       oe_n     = pin_s2[8];
  wire       bs2      = pin_s2[11];
  wire       bs1      = pin_s2[12];
  wire [1:0] action   = pin_s2[14:13];
  wire       xtal_rise = pin_s2[15] & ~pin_s3[15];
  wire       pl_rise  = pin_s2[10] & ~pin_s3[10];
  wire       wr_fall  = ~pin_s2[9] & pin_s3[9];
  wire       hv_rise  = pin_s2[16] & ~pin_s3[16];
  wire       hv_fall  = ~pin_s2[16] & pin_s3[16];

  reg [2:0]  state;
  reg [11:0] idx;
  reg [15:0] timer;
  reg [7:0]  cmd;
  reg [7:0]  addr_low;
  reg [7:0]  addr_high;
  reg [7:0]  data_low;
  reg [7:0]  data_high;
  reg        wr_pend;
  reg        pl_pend;
  reg [20:0] pl_data;
  reg        pu_latch;
  reg [7:0]  fuse_low;
  reg [7:0]  fuse_high;
  reg [7:0]  fuse_ext;

  reg [15:0] flash_mem [0:(1<<`PPP_FLASH_AW)-1];
  reg [7:0]  ee_mem    [0:(1<<`PPP_EE_AW)-1];
  reg [15:0] flash_buf [0:(1<<`PPP_WORD_BITS)-1];
  reg [7:0]  ee_buf    [0:(1<<`PPP_EEBYTE_BITS)-1];

  wire [11:0] flash_addr = {addr_high[3:0], addr_low};
  wire [8:0]  ee_addr    = {addr_high[0], addr_low};
  wire        first_lock_free = lock_bits[`PPP_LOCK_FIRST_BIT];
  wire        ee_keep    = ~fuse_high[`PPP_PRESERVE_BIT];
  wire        fifo_ready;
  wire        fifo_valid;
  wire [20:0] fifo_data;
  wire        drain      = (state == ST_IDLE);
  wire        start      = drain & wr_pend & ~fifo_valid;
  wire        is_ee_cmd  = (cmd == `PPP_CMD_EE_WR);

  // The preserve fuse acts from the stored copy, not the latched one. [R17]
  assign eeprom_preserve_fuse       = fuse_high[`PPP_PRESERVE_BIT];
  assign serial_program_enable_fuse = fuse_high_active[`PPP_SERIAL_EN_BIT];

  // Page loads queue here so a burst is not lost while a page write is running. [R12]
  ppp_fifo #(
    .WIDTH (21),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (pl_pend),
    .in_ready  (fifo_ready),
    .in_data   (pl_data),
    .out_valid (fifo_valid),
    .out_ready (drain),
    .out_data  (fifo_data)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= 17'h0ffff;
      pin_s2 <= 17'h0ffff;
      pin_s3 <= 17'h0ffff;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Loads: command, address and data stay until overwritten. [R1] [R25]
  always @(posedge sys_clk) begin
    if (rst) begin
      cmd       <= 8'h00;
      addr_low  <= 8'h00;
      addr_high <= 8'h00;
      data_low  <= 8'hff;
      data_high <= 8'hff;
    end else if (prog_mode & xtal_rise) begin
      case (action) // [R2]
        `PPP_ACT_ADDR: begin
          if (bs1) begin // [R9]
            addr_high <= din;
          end else begin
            addr_low <= din;
          end
        end
        `PPP_ACT_DATA: begin
          if (bs1) begin // [R9]
            data_high <= din;
          end else begin
            data_low <= din;
          end
        end
        `PPP_ACT_CMD: begin
          cmd <= din;
        end
        default: begin
        end
      endcase
    end
  end

  // A page load waits here while the FIFO is full; a second one meanwhile is dropped.
  always @(posedge sys_clk) begin
    if (rst) begin
      pl_pend <= 1'b0;
      pl_data <= 21'h000000;
    end else if (prog_mode & pl_rise & ~pl_pend) begin
      pl_pend <= 1'b1;
      pl_data <= {(is_ee_cmd ? {3'h0, addr_low[1:0]} : addr_low[4:0]),
                  data_high, data_low}; // [R14] [R15]
    end else if (fifo_ready) begin
      pl_pend <= 1'b0;
    end
  end

  // Sequencer for erase, page programming and the write delay. [R3] [R4] [R6]
  always @(posedge sys_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      idx       <= 12'h000;
      timer     <= 16'h0000;
      wr_pend   <= 1'b0;
      lock_bits <= `PPP_LOCK_RST;
      fuse_low  <= `PPP_FUSE_LOW_RST;
      fuse_high <= `PPP_FUSE_HIGH_RST;
      fuse_ext  <= `PPP_FUSE_EXT_RST;
    end else begin
      // A strobe arriving as the previous one is taken stays pending.
      if (prog_mode & wr_fall) begin
        wr_pend <= 1'b1;
      end else if (start) begin
        wr_pend <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          idx   <= 12'h000;
          timer <= WRITE_CYCLES;
          if (start) begin
            case (cmd)
              `PPP_CMD_ERASE: begin
                state <= ST_ERASE;
              end
              `PPP_CMD_FUSE_WR: begin
                state <= ST_WAIT;
                if (first_lock_free) begin // [R19]
                  // The serial enable fuse is written like any other bit here. [R22]
                  if (bs2) begin // [R10]
                    fuse_ext <= data_low;
                  end else if (bs1) begin
                    fuse_high <= data_low;
                  end else begin
                    fuse_low <= data_low;
                  end
                end
              end
              `PPP_CMD_LOCK_WR: begin
                // Lock bits only go towards programmed; only erase or reset clears them.
                lock_bits <= lock_bits & data_low;
                state     <= ST_WAIT;
              end
              `PPP_CMD_FLASH_WR: begin
                state <= first_lock_free ? ST_FLASH : ST_WAIT;
              end
              `PPP_CMD_EE_WR: begin
                state <= first_lock_free ? ST_EE : ST_WAIT;
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ERASE: begin
          idx <= idx + 12'h001;
          if (idx == 12'hfff) begin
            // Locks clear only after the whole program memory is erased; fuses stay. [R19]
            lock_bits <= `PPP_LOCK_RST;
            state     <= ST_WAIT;
          end
        end
        ST_FLASH: begin
          idx <= idx + 12'h001;
          if (idx[4:0] == 5'h1f) begin
            state <= ST_WAIT;
          end
        end
        ST_EE: begin
          idx <= idx + 12'h001;
          if (idx[1:0] == 2'h3) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          timer <= timer - 16'h0001;
          if (timer <= 16'h0001) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Storage arrays hold their contents through reset, as nonvolatile cells would.
  always @(posedge sys_clk) begin
    if (drain & fifo_valid) begin
      if (is_ee_cmd) begin
        ee_buf[fifo_data[17:16]] <= fifo_data[7:0];
      end else begin
        flash_buf[fifo_data[20:16]] <= fifo_data[15:0];
      end
    end
    if (state == ST_ERASE) begin
      flash_mem[idx] <= 16'hffff;
      if (~ee_keep) begin
        ee_mem[idx[8:0]] <= 8'hff;
      end
    end
    if (state == ST_FLASH) begin
      flash_mem[{flash_addr[11:5], idx[4:0]}] <= flash_buf[idx[4:0]]; // [R14]
    end
    if (state == ST_EE) begin
      ee_mem[{ee_addr[8:2], idx[1:0]}] <= ee_buf[idx[1:0]]; // [R15]
    end
  end

  // Entry latches the fuses; edits show only after exit. [R16] [R18]
  always @(posedge sys_clk) begin
    if (rst) begin
      prog_mode        <= 1'b0;
      pu_latch         <= 1'b1;
      fuse_low_active  <= `PPP_FUSE_LOW_RST;
      fuse_high_active <= `PPP_FUSE_HIGH_RST;
      fuse_ext_active  <= `PPP_FUSE_EXT_RST;
    end else begin
      pu_latch <= 1'b0;
      if (hv_rise & (pin_s2[14:12] == 3'h0) & ~pin_s2[10]) begin // [R13]
        prog_mode <= 1'b1;
      end else if (hv_fall) begin
        prog_mode <= 1'b0;
      end
      if (pu_latch | hv_rise | hv_fall) begin
        fuse_low_active  <= fuse_low;
        fuse_high_active <= fuse_high;
        fuse_ext_active  <= fuse_ext;
      end
    end
  end

  // Read-out is registered; the signature stays visible when locked. [R5] [R20] [R23]
  always @(posedge sys_clk) begin
    if (rst) begin
      oscillator_calibration_register <= CAL_BYTE; // [R21]
      data_out        <= 8'hff;
      data_oe_n       <= 1'b1;
      ready_busy_flag <= 1'b0;
    end else begin
      data_oe_n       <= oe_n | ~prog_mode; // [R11]
      ready_busy_flag <= (state == ST_IDLE) & ~wr_pend; // [R8]
      case (cmd)
        `PPP_CMD_FLASH_RD: begin
          data_out <= bs1 ? flash_mem[flash_addr][15:8] : flash_mem[flash_addr][7:0];
        end
        `PPP_CMD_EE_RD: begin
          data_out <= ee_mem[ee_addr];
        end
        `PPP_CMD_SIG_RD: begin
          if (bs1) begin
            data_out <= CAL_BYTE;
          end else begin
            case (addr_low[1:0])
              2'h0:    data_out <= SIG_BYTE0;
              2'h1:    data_out <= SIG_BYTE1;
              2'h2:    data_out <= SIG_BYTE2;
              default: data_out <= 8'hff;
            endcase
          end
        end
        `PPP_CMD_FUSE_RD: begin
          case ({bs2, bs1}) // [R10]
            2'h0:    data_out <= fuse_low;
            2'h1:    data_out <= lock_bits;
            2'h2:    data_out <= fuse_ext;
            default: data_out <= fuse_high;
          endcase
        end
        default: begin
          data_out <= 8'hff;
        end
      endcase
    end
  end
endmodule // ppp_port

// *** hw/ppp_consts.vh ***
// Constants of the parallel programming port: commands, pin bits, fuse layout, timing.
// Assumes a 100 MHz sys_clk and a synchronous active-high reset.
// What this block does
// R1: Crystal strobe rising edge performs selected load only.
// R2: Action select: address, data, command, or idle.
// R3: Write or read strobe executes loaded command.
// R4: Decode chip erase, fuse write, lock write.
// R5: Decode signature, fuse/lock, program memory reads.
// R6: Decode program write, EEPROM write, EEPROM read.
// R7: Programmer keeps every strobe at least 250 ns; the bench holds output enable low only 9 cycles (90 ns) per read.
// R8: Ready flag low while busy, high when ready.
// R9: Byte select one picks low or high byte.
// R10: Byte select two picks second high byte.
// R11: Data bus driven only while output enable low.
// R12: Page load strobe latches data into page buffer.
// R13: Programmer holds four entry pins low to enter.
// R14: Program memory: 128 pages of 32 words.
// R15: EEPROM: 128 pages of 4 bytes.
// R16: Fuses latched at entry, changes apply after exit.
// R17: EEPROM preserve fuse applies immediately.
// R18: Fuses also latched at power-up.
// R19: Erase keeps fuses; first lock bit blocks fuses.
// R20: Three identification bytes readable even when locked.
// R21: Calibration byte copied into oscillator register at reset.
// R22: Serial enable fuse changeable only over parallel port.
// R23: Fuse and lock bits read 0 when programmed.
// R24: Programmer waits 10 us and 300 us after entry.
// R25: Command and address kept across operations.
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH

`define PPP_CMD_ERASE    8'h80
`define PPP_CMD_FUSE_WR  8'h40
`define PPP_CMD_LOCK_WR  8'h20
`define PPP_CMD_FLASH_WR 8'h10
`define PPP_CMD_EE_WR    8'h11
`define PPP_CMD_SIG_RD   8'h08
`define PPP_CMD_FUSE_RD  8'h04
`define PPP_CMD_FLASH_RD 8'h02
`define PPP_CMD_EE_RD    8'h03

`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD  2'h2

`define PPP_FUSE_LOW_RST  8'h62
`define PPP_FUSE_HIGH_RST 8'hdf
`define PPP_FUSE_EXT_RST  8'hf9
`define PPP_LOCK_RST      8'hff
`define PPP_PRESERVE_BIT  3
`define PPP_SERIAL_EN_BIT 5
`define PPP_LOCK_FIRST_BIT 0

`define PPP_FLASH_AW 12
`define PPP_EE_AW    9
`define PPP_WORD_BITS 5
`define PPP_EEBYTE_BITS 2

`define PPP_CLK_MHZ 100
`define PPP_WRITE_TIME_NS 4500
`define PPP_WRITE_CYCLES ((`PPP_WRITE_TIME_NS * `PPP_CLK_MHZ + 999) / 1000)

`endif

// *** test/ppp_port_monitor.sv ***
// Checker of the programming port's pin-level behaviour.
// Assumes one clock and a synchronous active-high reset; sees only the port's pins.
module ppp_port_monitor #(
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       write_strobe_n,
  input wire logic       output_enable_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       ready_busy_flag,
  input wire logic       prog_mode,
  input wire logic [7:0] fuse_low_active,
  input wire logic [7:0] fuse_high_active,
  input wire logic [7:0] fuse_ext_active,
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] oscillator_calibration_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_state: assert property (disable iff (1'b0) rst |=> !ready_busy_flag && data_oe_n
    && lock_bits == 8'hff && data_out == 8'hff) else $error("reset state wrong");
  a_oscillator_calibration_register_copy: assert property (oscillator_calibration_register == CAL_BYTE)
    else $error("calibration register differs from calibration byte");
  a_bus_release: assert property (output_enable_n [*5] |-> data_oe_n)
    else $error("bus driven with output enable high");
  a_drive_cause: assert property ($fell(data_oe_n) |-> !output_enable_n && prog_mode)
    else $error("bus driven without cause");
  a_idle_undriven: assert property (!prog_mode [*3] |-> data_oe_n)
    else $error("bus driven outside programming mode");
  a_busy_cause: assert property ($fell(ready_busy_flag) |-> !write_strobe_n)
    else $error("busy without write strobe");
  a_busy_length: assert property ($fell(ready_busy_flag) |-> !ready_busy_flag [*8])
    else $error("busy period too short");
  a_idle_ready: assert property (!prog_mode [*5] |-> ready_busy_flag)
    else $error("not ready while idle");
  a_fuse_hold: assert property (prog_mode [*4] |-> $stable(fuse_low_active)
    && $stable(fuse_high_active) && $stable(fuse_ext_active))
    else $error("active fuses changed inside programming mode");
  a_lock_clear: assert property ((lock_bits & ~$past(lock_bits)) == 8'h00
    || lock_bits == 8'hff) else $error("lock bit unprogrammed without erase");
endmodule // ppp_port_monitor

bind ppp_port ppp_port_monitor #(.CAL_BYTE(CAL_BYTE)) i_mon (.sys_clk, .rst,
  .write_strobe_n, .output_enable_n, .data_out, .data_oe_n, .ready_busy_flag, .prog_mode,
  .fuse_low_active, .fuse_high_active, .fuse_ext_active, .lock_bits,
  .oscillator_calibration_register);

// *** test/ppp_programmer.sv ***
// Model of the external programmer that drives the port's pins.
// Assumes the device samples every pin on sys_clk through synchronisers.
module ppp_programmer (
  input  wire logic  sys_clk,
  output logic       hv_detect,
  output logic       crystal_input_strobe,
  output logic       action_select_high,
  output logic       action_select_low,
  output logic       byte_select_one,
  output logic       byte_select_two,
  output logic       page_load_strobe,
  output logic       write_strobe_n,
  output logic       output_enable_n,
  output logic [7:0] data_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {hv_detect, crystal_input_strobe, page_load_strobe, byte_select_one} = 4'h0;
    {action_select_high, action_select_low, byte_select_two} = 3'h6;
    {write_strobe_n, output_enable_n} = 2'h3;
    data_drive = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Strobe levels last 26 cycles, just over the 250 ns minimum width.
  task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] val);
    @(posedge sys_clk);
    {action_select_high, action_select_low} <= act;
    byte_select_one <= b1;
    data_drive <= val;
    hold(26);
    crystal_input_strobe <= 1'b1;
    hold(26);
    crystal_input_strobe <= 1'b0;
    hold(26);
  endtask
  task automatic page;
    @(posedge sys_clk);
    page_load_strobe <= 1'b1;
    hold(26);
    page_load_strobe <= 1'b0;
    hold(26);
  endtask
  task automatic set_pins(input logic b1, input logic b2, input logic wr, input logic oe);
    @(posedge sys_clk);
    byte_select_one <= b1;
    byte_select_two <= b2;
    write_strobe_n <= wr;
    output_enable_n <= oe;
  endtask
  // The entry pins are low well before the voltage changes, then settle times pass.
  task automatic enter(input logic on);
    @(posedge sys_clk);
    {page_load_strobe, action_select_high, action_select_low, byte_select_one} <= 4'h0;
    hold(4);
    hv_detect <= on;
    hold(on ? 31000 : 10);
  endtask
endmodule // ppp_programmer

// *** test/parallel_programming_port_test.sv ***
// Self-checking bench of the programming port driven by the programmer model.
// Assumes a 100 MHz clock; the write time is shortened through WRITE_CYCLES.
module parallel_programming_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] adr;
    logic       bs1;
    logic       bs2;
    logic [7:0] exp;
  } ppp_row_t;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       hv_detect, crystal_input_strobe, action_select_high, action_select_low;
  logic       byte_select_one, byte_select_two, page_load_strobe;
  logic       write_strobe_n, output_enable_n, data_oe_n, ready_busy_flag, prog_mode;
  logic       eeprom_preserve_fuse, serial_program_enable_fuse;
  logic [7:0] data_drive, data_in, data_out, fuse_low_active, fuse_high_active;
  logic [7:0] fuse_ext_active, lock_bits, oscillator_calibration_register;
  int         miscompares = 0;
  int         checked = 0;
  ppp_row_t   rows [14];
  always #5 sys_clk = ~sys_clk;
  // An undriven bus shows the inverse of the last value instead of holding it.
  assign data_in = !data_oe_n ? data_out : (output_enable_n ? data_drive : ~data_drive);
  ppp_programmer i_prog (.sys_clk, .hv_detect, .crystal_input_strobe, .action_select_high,
    .action_select_low, .byte_select_one, .byte_select_two, .page_load_strobe,
    .write_strobe_n, .output_enable_n, .data_drive);
  ppp_port #(.WRITE_CYCLES(16'd10)) i_dut (.sys_clk, .rst, .hv_detect, .crystal_input_strobe,
    .action_select_high, .action_select_low, .byte_select_one, .byte_select_two,
    .page_load_strobe, .write_strobe_n, .output_enable_n, .data_in, .data_out, .data_oe_n,
    .ready_busy_flag, .prog_mode, .fuse_low_active, .fuse_high_active, .fuse_ext_active,
    .lock_bits, .eeprom_preserve_fuse, .serial_program_enable_fuse,
    .oscillator_calibration_register);

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic execute(input logic b1, input logic b2);
    int n;
    n = 0;
    i_prog.set_pins(b1, b2, 1'b0, 1'b1);
    cyc(6);
    check("busy", ready_busy_flag, 1'b0);
    cyc(20);
    i_prog.set_pins(b1, b2, 1'b1, 1'b1);
    while (ready_busy_flag !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    check("ready", ready_busy_flag, 1'b1);
  endtask
  task automatic read_row(input ppp_row_t r);
    i_prog.load(2'h2, 1'b0, r.cmd);
    i_prog.load(2'h0, 1'b0, r.adr);
    i_prog.set_pins(r.bs1, r.bs2, 1'b1, 1'b0);
    cyc(8);
    check("read", {data_oe_n, data_in}, {1'b0, r.exp});
    i_prog.set_pins(r.bs1, r.bs2, 1'b1, 1'b1);
    cyc(8);
  endtask

  initial begin
    #1_000_000;
    miscompares++;
    final_report;
  end

  initial begin
    rows = '{'{8'h08, 8'h00, 1'b0, 1'b0, 8'h5a}, '{8'h08, 8'h01, 1'b0, 1'b0, 8'h3c},
             '{8'h08, 8'h02, 1'b0, 1'b0, 8'h0f}, '{8'h08, 8'h03, 1'b0, 1'b0, 8'hff},
             '{8'h08, 8'h00, 1'b1, 1'b0, 8'h80}, '{8'h04, 8'h00, 1'b0, 1'b0, 8'h55},
             '{8'h04, 8'h00, 1'b1, 1'b0, 8'hfe}, '{8'h04, 8'h00, 1'b0, 1'b1, 8'hf9},
             '{8'h04, 8'h00, 1'b1, 1'b1, 8'hd7}, '{8'h02, 8'h21, 1'b0, 1'b0, 8'h34},
             '{8'h02, 8'h21, 1'b1, 1'b0, 8'h12}, '{8'h02, 8'h22, 1'b0, 1'b0, 8'hcd},
             '{8'h02, 8'h22, 1'b1, 1'b0, 8'hab}, '{8'h03, 8'h05, 1'b0, 1'b0, 8'h96}};
    repeat (8) @(posedge sys_clk);
    #1;
    check("reset", {fuse_low_active, fuse_high_active, fuse_ext_active, lock_bits,
      oscillator_calibration_register, data_out, ready_busy_flag, data_oe_n},
      {48'h62dff9ff80ff, 2'b01});
    @(posedge sys_clk);
    rst <= 1'b0;
    cyc(5);
    check("idle", {ready_busy_flag, prog_mode}, 2'b10);
    i_prog.enter(1'b1);
    check("entry", prog_mode, 1'b1);
    // Two words of flash page 1, then one EEPROM byte.
    i_prog.load(2'h2, 1'b0, 8'h10);
    for (int i = 0; i < 2; i++) begin
      i_prog.load(2'h0, 1'b0, 8'h21 + i[7:0]);
      i_prog.load(2'h1, 1'b0, i ? 8'hcd : 8'h34);
      i_prog.load(2'h1, 1'b1, i ? 8'hab : 8'h12);
      i_prog.page;
    end
    i_prog.load(2'h0, 1'b1, 8'h00);
    execute(1'b0, 1'b0);
    i_prog.load(2'h2, 1'b0, 8'h11);
    i_prog.load(2'h0, 1'b0, 8'h05);
    i_prog.load(2'h1, 1'b0, 8'h96);
    i_prog.page;
    execute(1'b0, 1'b0);
    i_prog.load(2'h2, 1'b0, 8'h40);
    i_prog.load(2'h1, 1'b0, 8'h55);
    execute(1'b0, 1'b0);
    i_prog.load(2'h1, 1'b0, 8'hd7);
    execute(1'b1, 1'b0);
    check("fuses", {fuse_low_active, fuse_high_active, eeprom_preserve_fuse},
      17'h0c5be);
    i_prog.load(2'h2, 1'b0, 8'h20);
    i_prog.load(2'h1, 1'b0, 8'hfe);
    execute(1'b0, 1'b0);
    check("lock", lock_bits, 8'hfe);
    // A fuse write after the first lock bit is programmed must be ignored.
    i_prog.load(2'h2, 1'b0, 8'h40);
    i_prog.load(2'h1, 1'b0, 8'h00);
    execute(1'b0, 1'b0);
    foreach (rows[i]) read_row(rows[i]);
    i_prog.load(2'h2, 1'b0, 8'h80);
    execute(1'b0, 1'b0);
    check("erase", lock_bits, 8'hff);
    read_row('{8'h03, 8'h05, 1'b0, 1'b0, 8'h96});
    read_row('{8'h04, 8'h00, 1'b0, 1'b0, 8'h55});
    i_prog.enter(1'b0);
    check("exit", {fuse_low_active, fuse_high_active, serial_program_enable_fuse},
      17'h0abae);
    final_report;
  end
endmodule // parallel_programming_port_test
